// *** logic/sbs_defs.svh ***
// Purpose: Constants of the synchronous burst SRAM control block.
// Assumes: A 10 MHz clock, a period of 100 ns.
// Notes:   Times are in ns; cycle counts are derived from them.
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
`define SBS_CLK_PERIOD_NS      100
`define SBS_ORDER_CFG_NS       34
`define SBS_ORDER_CFG_CYC      ((`SBS_ORDER_CFG_NS + `SBS_CLK_PERIOD_NS - 1) / `SBS_CLK_PERIOD_NS)
`define SBS_SLEEP_PULSE_NS     100
`define SBS_SLEEP_RECOVERY_NS  100
`define SBS_ADDR_W             18
`define SBS_LANES              4
`define SBS_LANE_W             9
`define SBS_FIFO_DEPTH         8
`define SBS_BURST_START        2'h0
`define SBS_ORDER_RESET        1'b1
`endif

// *** logic/sbs_fifo.sv ***
// Purpose: Small FIFO with valid and ready on both sides.
// Assumes: Depth is a power of two.
// Notes:   The write side sees ready low only when every slot holds a word.
module sbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and control
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             clk_en_in,
    // Filling side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Draining side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
            $error("sbs_fifo: DEPTH must be a power of two and at least 2");
    end

    logic [WIDTH-1:0] slots [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [CW-1:0]    count_r;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count_r != CW'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign out_data_out  = slots[rd_ptr_r];
    assign push = clk_en_in && in_valid_in && in_ready_out;
    assign pop  = clk_en_in && out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push)
            slots[wr_ptr_r] <= in_data_in;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule // sbs_fifo

// *** logic/sbs_pkg.sv ***
// Purpose: Types shared by the burst SRAM control block.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are one-hot.
package sbs_pkg;
    typedef enum logic [3:0] {
        SBS_IDLE  = 4'h1,
        SBS_READ  = 4'h2,
        SBS_WRITE = 4'h4,
        SBS_SLEEP = 4'h8
    } sbs_state_type;

    typedef enum logic {
        SBS_LINEAR      = 1'b0,
        SBS_INTERLEAVED = 1'b1
    } sbs_order_type;
endpackage

// *** logic/sbs_sram_ctrl.sv ***
// Purpose: Control and array of a synchronous burst SRAM, flow-through reads.
// Assumes: All inputs are synchronous to MCLK_IN except output enable and sleep.
// Notes:   Writes pass an 8-word queue before reaching the array; it drains
//          one word a cycle and stalls while sleep is requested or the clock enable is low.
`include "sbs_defs.svh"
module sbs_sram_ctrl #(
    parameter int ADDR_W     = `SBS_ADDR_W,
    parameter int LANES      = `SBS_LANES,
    parameter int LANE_W     = `SBS_LANE_W,
    parameter int FIFO_DEPTH = `SBS_FIFO_DEPTH
) (
    // Clock, reset and enable
    input  wire logic                     MCLK_IN,
    input  wire logic                     RST_N_IN,
    input  wire logic                     CLK_EN_IN,
    // Address and selects
    input  wire logic [ADDR_W-1:0]        ADDR_IN,
    input  wire logic                     CHIP_EN_N_IN,
    input  wire logic                     SELECT_HIGH_IN,
    input  wire logic                     SELECT_LOW_N_IN,
    input  wire logic                     CPU_ADDR_STROBE_N_IN,
    input  wire logic                     CTRL_ADDR_STROBE_N_IN,
    input  wire logic                     BURST_ADVANCE_N_IN,
    // Write controls
    input  wire logic                     GLOBAL_WRITE_N_IN,
    input  wire logic                     LANE_WRITE_ENABLE_N_IN,
    input  wire logic [LANES-1:0]         LANE_SELECT_N_IN,
    // Asynchronous and static controls
    input  wire logic                     OUTPUT_EN_N_IN,
    input  wire logic                     SLEEP_REQUEST_IN,
    input  wire logic                     BURST_ORDER_SELECT_IN,
    // Data pins
    input  wire logic [LANES*LANE_W-1:0]  DQ_IN,
    output logic [LANES*LANE_W-1:0]       DQ_OUT,
    output logic                          DQ_OE_OUT,
    // Status
    output logic                          WR_READY_OUT,
    output logic                          STANDBY_OUT,
    output logic                          SLEEP_OUT,
    output sbs_pkg::sbs_order_type        BURST_ORDER_OUT
);
    import sbs_pkg::*;

    localparam int DATA_W = LANES * LANE_W;
    localparam int PUSH_W = ADDR_W + LANES + DATA_W;
    localparam int CFG_CYC = (`SBS_ORDER_CFG_CYC < 1) ? 1 : `SBS_ORDER_CFG_CYC;

    initial begin
        if ((LANES != 2 && LANES != 4) || ADDR_W < 3 || LANE_W < 1)
            $error("sbs_sram_ctrl: LANES must be 2 or 4 and ADDR_W at least 3");
    end

    function automatic logic [LANES-1:0] lane_mask(input logic gw_n, input logic bwe_n,
                                                    input logic [LANES-1:0] sel_n);
        if (!gw_n)
            return '1;
        else if (!bwe_n)
            return ~sel_n;
        else
            return '0;
    endfunction

    function automatic logic [1:0] burst_low(input logic [1:0] base, input logic [1:0] cnt,
                                              input sbs_order_type order);
        if (order == SBS_INTERLEAVED)
            return base ^ cnt;
        else
            return base + cnt;
    endfunction

    sbs_state_type        state_r;
    sbs_state_type        state_nxt;
    sbs_order_type        order_r;
    logic [ADDR_W-3:0]    upper_r;
    logic [ADDR_W-3:0]    upper_nxt;
    logic [1:0]           base_r;
    logic [1:0]           base_nxt;
    logic [1:0]           cnt_r;
    logic [1:0]           cnt_nxt;
    logic [1:0]           cfg_cnt_r;
    logic                 cfg_done;
    logic                 sel_ok;
    logic                 cpu_take;
    logic                 ctrl_take;
    logic                 in_burst;
    logic [LANES-1:0]     wr_mask;
    logic                 wr_now;
    logic                 wr_push;
    logic [ADDR_W-1:0]    cur_addr;
    logic [ADDR_W-1:0]    push_addr;
    logic                 fifo_ready;
    logic                 drain_valid;
    logic                 drain_ready;
    logic [PUSH_W-1:0]    drain_word;
    logic [ADDR_W-1:0]    drain_addr;
    logic [LANES-1:0]     drain_mask;
    logic [DATA_W-1:0]    drain_data;

    // The order pin is only watched for its setup time after reset, whether it changes or not.
    assign cfg_done = (cfg_cnt_r == 2'(CFG_CYC));

    assign sel_ok    = !CHIP_EN_N_IN && SELECT_HIGH_IN && !SELECT_LOW_N_IN;
    assign cpu_take  = !CPU_ADDR_STROBE_N_IN && !CHIP_EN_N_IN;
    assign ctrl_take = !cpu_take && !CTRL_ADDR_STROBE_N_IN;
    assign in_burst  = (state_r == SBS_READ) || (state_r == SBS_WRITE);
    assign wr_mask   = lane_mask(GLOBAL_WRITE_N_IN, LANE_WRITE_ENABLE_N_IN, LANE_SELECT_N_IN);

    always_comb begin
        state_nxt = state_r;
        upper_nxt = upper_r;
        base_nxt  = base_r;
        cnt_nxt   = cnt_r;
        wr_now    = 1'b0;
        if (SLEEP_REQUEST_IN) begin
            state_nxt = SBS_SLEEP;
        end else if (!cfg_done || state_r == SBS_SLEEP) begin
            state_nxt = SBS_IDLE;
        end else if (cpu_take || ctrl_take) begin
            if (sel_ok) begin
                upper_nxt = ADDR_IN[ADDR_W-1:2];
                base_nxt  = ADDR_IN[1:0];
                cnt_nxt   = `SBS_BURST_START;
                // The processor strobe always begins a read.
                wr_now    = ctrl_take && (wr_mask != '0);
                state_nxt = wr_now ? SBS_WRITE : SBS_READ;
            end else begin
                state_nxt = SBS_IDLE;
            end
        end else if (in_burst) begin
            if (!BURST_ADVANCE_N_IN)
                cnt_nxt = cnt_r + 1'b1;
            wr_now    = (wr_mask != '0);
            state_nxt = wr_now ? SBS_WRITE : SBS_READ;
        end
    end

    assign push_addr = {upper_nxt, burst_low(base_nxt, cnt_nxt, order_r)};
    assign cur_addr  = {upper_r, burst_low(base_r, cnt_r, order_r)};
    assign wr_push   = CLK_EN_IN && wr_now && fifo_ready;

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            cfg_cnt_r <= 2'h0;
            order_r   <= sbs_order_type'(`SBS_ORDER_RESET);
        end else if (CLK_EN_IN && !cfg_done) begin
            cfg_cnt_r <= cfg_cnt_r + 1'b1;
            order_r   <= sbs_order_type'(BURST_ORDER_SELECT_IN);
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            state_r <= SBS_IDLE;
            upper_r <= '0;
            base_r  <= `SBS_BURST_START;
            cnt_r   <= `SBS_BURST_START;
        end else if (CLK_EN_IN) begin
            state_r <= state_nxt;
            upper_r <= upper_nxt;
            base_r  <= base_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            STANDBY_OUT     <= 1'b1;
            SLEEP_OUT       <= 1'b0;
            WR_READY_OUT    <= 1'b0;
            BURST_ORDER_OUT <= sbs_order_type'(`SBS_ORDER_RESET);
        end else if (CLK_EN_IN) begin
            STANDBY_OUT     <= (state_nxt == SBS_IDLE);
            SLEEP_OUT       <= (state_nxt == SBS_SLEEP);
            WR_READY_OUT    <= fifo_ready;
            BURST_ORDER_OUT <= cfg_done ? order_r : sbs_order_type'(BURST_ORDER_SELECT_IN);
        end
    end

    // Captured words carry address, lane mask and data from the same edge.
    sbs_fifo #(
        .WIDTH (PUSH_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_queue (
        .clk_in        (MCLK_IN),
        .rst_n_in      (RST_N_IN),
        .clk_en_in     (CLK_EN_IN),
        .in_valid_in   (wr_now),
        .in_ready_out  (fifo_ready),
        .in_data_in    ({push_addr, wr_mask, DQ_IN}),
        .out_valid_out (drain_valid),
        .out_ready_in  (drain_ready),
        .out_data_out  (drain_word)
    );

    // Holding the queue in sleep keeps the array quiet; queued words land on wake.
    assign drain_ready = !SLEEP_REQUEST_IN;
    assign drain_addr  = drain_word[PUSH_W-1 -: ADDR_W];
    assign drain_mask  = drain_word[DATA_W +: LANES];
    assign drain_data  = drain_word[DATA_W-1:0];

    // Each lane has an array of its own, so every lane has exactly one writer.
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] lane_mem [2**ADDR_W];

        always_ff @(posedge MCLK_IN) begin
            if (CLK_EN_IN && drain_valid && drain_ready && drain_mask[g])
                lane_mem[drain_addr] <= drain_data[g*LANE_W +: LANE_W];
        end

        // Flow-through: the pins follow the array with no output register.
        assign DQ_OUT[g*LANE_W +: LANE_W] = lane_mem[cur_addr];
    end

    // Output enable and sleep reach the pins without the clock.
    assign DQ_OE_OUT = (state_r == SBS_READ) && !OUTPUT_EN_N_IN && !SLEEP_REQUEST_IN;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    sequence seq_continue;
        CLK_EN_IN && !SLEEP_REQUEST_IN && cfg_done && in_burst
            && CPU_ADDR_STROBE_N_IN && CTRL_ADDR_STROBE_N_IN;
    endsequence

    sequence seq_step;
        seq_continue ##0 !BURST_ADVANCE_N_IN;
    endsequence

    a_sleep_float: assert property (SLEEP_REQUEST_IN |-> !DQ_OE_OUT)
        else $error("data pins driven during sleep");

    a_write_float: assert property (state_r == SBS_WRITE |-> !DQ_OE_OUT)
        else $error("data pins driven during a write cycle");

    a_deselect_idle: assert property (
        CLK_EN_IN && !SLEEP_REQUEST_IN && cfg_done && state_r != SBS_SLEEP
            && (cpu_take || ctrl_take) && !sel_ok |=> state_r == SBS_IDLE && !DQ_OE_OUT)
        else $error("deselect did not float and idle");

    a_oe_read_drive: assert property (
        state_r == SBS_READ && !OUTPUT_EN_N_IN && !SLEEP_REQUEST_IN |-> DQ_OE_OUT)
        else $error("read with output enable low did not drive");

    a_global_all_lanes: assert property (wr_push && !GLOBAL_WRITE_N_IN |-> wr_mask == '1)
        else $error("global write did not select every lane");

    a_lane_select_map: assert property (
        wr_push && GLOBAL_WRITE_N_IN |-> wr_mask == ~LANE_SELECT_N_IN)
        else $error("lane mask differs from lane selects");

    a_read_no_push: assert property (
        GLOBAL_WRITE_N_IN && (LANE_WRITE_ENABLE_N_IN || LANE_SELECT_N_IN == '1) |-> !wr_now)
        else $error("read cycle queued a write");

    a_cpu_no_write: assert property (cpu_take |-> !wr_now)
        else $error("processor strobe started a write");

    a_burst_step: assert property (
        seq_step |=> cnt_r == 2'($past(cnt_r) + 2'h1) && upper_r == $past(upper_r))
        else $error("burst did not step with fixed upper bits");

    a_burst_hold: assert property (
        seq_continue ##0 BURST_ADVANCE_N_IN |=> $stable(cnt_r) && $stable(cur_addr))
        else $error("burst address moved while advance was high");

    a_burst_wrap: assert property (
        seq_step ##1 seq_step ##1 seq_step ##1 seq_step |=> cur_addr == $past(cur_addr, 4))
        else $error("burst did not wrap to its start");

    a_interleave_order: assert property (
        order_r == SBS_INTERLEAVED && in_burst |-> cur_addr[1:0] == (base_r ^ cnt_r))
        else $error("interleaved burst order wrong");

    a_wake_idle: assert property (
        CLK_EN_IN && state_r == SBS_SLEEP && !SLEEP_REQUEST_IN |=> state_r == SBS_IDLE)
        else $error("wake from sleep did not idle");

    a_order_static: assert property (cfg_done |=> $stable(order_r))
        else $error("burst order changed after configuration");

    a_linear_order: assert property (
        order_r == SBS_LINEAR && in_burst |-> cur_addr[1:0] == 2'(base_r + cnt_r))
        else $error("linear burst order wrong");

    a_clk_en_freeze: assert property (
        !CLK_EN_IN |=> $stable(state_r) && $stable(cnt_r) && $stable(order_r))
        else $error("state moved while the clock enable was low");

    a_sleep_enter: assert property (
        CLK_EN_IN && SLEEP_REQUEST_IN |=> state_r == SBS_SLEEP && SLEEP_OUT)
        else $error("sleep request did not enter sleep");

    a_standby_flag: assert property (STANDBY_OUT == (state_r == SBS_IDLE))
        else $error("standby flag differs from the idle state");

    a_write_queued: assert property (wr_push |=> drain_valid)
        else $error("accepted write did not reach the queue");

    a_cpu_read: assert property (
        CLK_EN_IN && !SLEEP_REQUEST_IN && cfg_done && state_r != SBS_SLEEP
            && cpu_take && sel_ok |=> state_r == SBS_READ)
        else $error("processor strobe did not start a read");
endmodule // sbs_sram_ctrl

// *** verif/sbs_host_model.sv ***
// Purpose: Bus master model that drives the burst SRAM control block.
// Assumes: Default widths; each request is launched just after a rising edge.
// Notes:   The data lines are inverted on every request whose write controls select no lane.
module sbs_host_model (
    // Clock
    input  wire logic   clk_in,
    // Address, selects and strobes
    output logic [17:0] a_out,
    output logic        ce_n_out,
    output logic        selh_out,
    output logic        sell_n_out,
    output logic        cstb_n_out,
    output logic        kstb_n_out,
    output logic        step_n_out,
    // Write controls
    output logic        glw_n_out,
    output logic        lwe_n_out,
    output logic [3:0]  lsel_n_out,
    // Static and asynchronous controls
    output logic        oe_n_out,
    output logic        slp_out,
    output logic        ord_out,
    // Data
    output logic [35:0] d_out
);
    initial begin
        {cstb_n_out, kstb_n_out, step_n_out, ce_n_out} = 4'hF;
        {selh_out, sell_n_out, glw_n_out, lwe_n_out} = 4'hB;
        {lsel_n_out, oe_n_out, slp_out} = 6'h3C;
        ord_out = 1'b1;
        a_out = 18'h0;
        d_out = 36'h0;
    end

    // Strobes are {cpu, controller, chip enable, advance}; writes {global, lane enable, lanes}.
    task automatic cyc(input logic [3:0] stb, input logic [17:0] a,
                       input logic [5:0] w, input logic [35:0] d);
        @(posedge clk_in);
        {cstb_n_out, kstb_n_out, ce_n_out, step_n_out} <= stb;
        {glw_n_out, lwe_n_out, lsel_n_out} <= w;
        a_out <= a;
        // Stale write data must never look valid, so it is inverted when no write claims it.
        d_out <= (w[5] && (w[4] || &w[3:0])) ? ~d_out : d;
    endtask

    task automatic rd(input logic cpu, input logic [17:0] a);
        cyc({~cpu, cpu, 2'b01}, a, 6'h3F, 36'h0);
    endtask

    task automatic wr(input logic [5:0] w, input logic [17:0] a, input logic [35:0] d);
        cyc(4'h9, a, w, d);
    endtask

    task automatic nxt(input logic hold);
        cyc({3'b110, hold}, a_out, 6'h3F, 36'h0);
    endtask

    // Output enable, sleep and order change just after a rising edge like the rest.
    task automatic pins(input logic oe_n, input logic slp, input logic ord);
        @(posedge clk_in);
        oe_n_out <= oe_n;
        slp_out  <= slp;
        ord_out  <= ord;
    endtask

    task automatic desel();
        cyc(4'hB, 18'h0, 6'h3F, 36'h0);
    endtask
endmodule // sbs_host_model

// *** verif/test_sync_burst_sram_control.sv ***
// Purpose: Self-checking bench for the burst SRAM control block.
// Assumes: Default widths, 36-bit words in four 9-bit lanes, lane 0 lowest.
// Notes:   A request shows its result in the cycle after the one it is launched in.
module test_sync_burst_sram_control import sbs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    int n_errors = 0;
    int total_checks = 0;
    wire logic [17:0] a;
    wire logic [35:0] d, q;
    wire logic [3:0] lsel_n;
    wire logic ce_n, selh, sell_n, cstb_n, kstb_n, step_n, glw_n, lwe_n;
    wire logic oe_n, slp, ord, oe, wrdy, stby, sleeping;
    sbs_order_type bord;

    always #50 mclk = ~mclk;

    sbs_host_model i_host (.clk_in(mclk), .a_out(a), .ce_n_out(ce_n), .selh_out(selh),
        .sell_n_out(sell_n), .cstb_n_out(cstb_n), .kstb_n_out(kstb_n), .step_n_out(step_n),
        .glw_n_out(glw_n), .lwe_n_out(lwe_n), .lsel_n_out(lsel_n), .oe_n_out(oe_n),
        .slp_out(slp), .ord_out(ord), .d_out(d));

    sbs_sram_ctrl i_dut (
        .MCLK_IN               (mclk),
        .RST_N_IN              (rst_n),
        .CLK_EN_IN             (clk_en),
        .ADDR_IN               (a),
        .CHIP_EN_N_IN          (ce_n),
        .SELECT_HIGH_IN        (selh),
        .SELECT_LOW_N_IN       (sell_n),
        .CPU_ADDR_STROBE_N_IN  (cstb_n),
        .CTRL_ADDR_STROBE_N_IN (kstb_n),
        .BURST_ADVANCE_N_IN    (step_n),
        .GLOBAL_WRITE_N_IN     (glw_n),
        .LANE_WRITE_ENABLE_N_IN(lwe_n),
        .LANE_SELECT_N_IN      (lsel_n),
        .OUTPUT_EN_N_IN        (oe_n),
        .SLEEP_REQUEST_IN      (slp),
        .BURST_ORDER_SELECT_IN (ord),
        .DQ_IN                 (d),
        .DQ_OUT                (q),
        .DQ_OE_OUT             (oe),
        .WR_READY_OUT          (wrdy),
        .STANDBY_OUT           (stby),
        .SLEEP_OUT             (sleeping),
        .BURST_ORDER_OUT       (bord)
    );

    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic do_reset(input logic o);
        i_host.pins(1'b0, 1'b0, o);
        rst_n <= 1'b0;
        repeat (7) @(posedge mclk);
        @(negedge mclk);
        chk("standby", 36'h1, 36'(stby));
        chk("dq_oe", 36'h0, 36'(oe));
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(negedge mclk);
        chk("order", 36'(o), 36'(bord));
        chk("wr_ready", 36'h1, 36'(wrdy));
    endtask

    task automatic s_lanes();
        i_host.wr(6'h0A, 18'h00010, 36'h123456789);
        i_host.wr(6'h20, 18'h00011, 36'hABCDEF012);
        i_host.rd(1'b0, 18'h00010);
        i_host.rd(1'b1, 18'h00011);
        @(negedge mclk);
        chk("global write", 36'h123456789, q);
        i_host.desel();
        @(negedge mclk);
        chk("all lanes write", 36'hABCDEF012, q);
        i_host.wr(6'h1F, 18'h00020, 36'h0);
        for (int i = 0; i < 4; i++) begin
            i_host.wr({2'b10, ~(4'h1 << i)}, 18'h00020, 36'hFFFFFFFFF);
            i_host.rd(1'b0, 18'h00020);
            @(negedge mclk);
            chk("dq_oe write", 36'h0, 36'(oe));
            i_host.desel();
            @(negedge mclk);
            chk("lane write", (36'h1 << (9 * (i + 1))) - 36'h1, q);
        end
        i_host.wr(6'h2F, 18'h00020, 36'h0);
        i_host.cyc(4'h5, 18'h00020, 6'h0F, 36'h0);
        i_host.rd(1'b0, 18'h00020);
        i_host.desel();
        clk_en <= 1'b0;
        repeat (2) @(negedge mclk);
        chk("no write", 36'hFFFFFFFFF, q);
        chk("frozen standby", 36'h0, 36'(stby));
        chk("frozen dq_oe", 36'h1, 36'(oe));
        @(posedge mclk);
        clk_en <= 1'b1;
    endtask

    task automatic s_burst(input logic o, input logic cpu);
        logic [1:0] c;
        logic [1:0] lo;
        c = 2'h0;
        for (int j = 0; j < 4; j++) begin
            i_host.wr(6'h1F, {16'h2ABC, 2'(j)}, 36'h5A5A5A5A0 | 36'(j));
        end
        i_host.rd(cpu, {16'h2ABC, 2'h1});
        for (int k = 0; k < 7; k++) begin
            i_host.nxt(k == 2);
            @(negedge mclk);
            lo = o ? (2'h1 ^ c) : (2'h1 + c);
            chk("burst word", 36'h5A5A5A5A0 | 36'(lo), q);
            if (k != 2) begin
                c = c + 2'h1;
            end
        end
        i_host.desel();
    endtask

    task automatic s_oe();
        i_host.rd(1'b0, 18'h00010);
        i_host.nxt(1'b1);
        @(negedge mclk);
        chk("dq_oe read", 36'h1, 36'(oe));
        chk("held read", 36'h123456789, q);
        i_host.pins(1'b1, 1'b0, 1'b1);
        #1;
        chk("dq_oe float", 36'h0, 36'(oe));
        i_host.pins(1'b0, 1'b0, 1'b1);
        #1;
        chk("dq_oe again", 36'h1, 36'(oe));
        i_host.desel();
        i_host.nxt(1'b0);
        i_host.nxt(1'b0);
        @(negedge mclk);
        chk("dq_oe idle", 36'h0, 36'(oe));
        chk("standby", 36'h1, 36'(stby));
    endtask

    task automatic s_sleep();
        i_host.rd(1'b1, 18'h00011);
        i_host.nxt(1'b1);
        @(negedge mclk);
        chk("dq_oe awake", 36'h1, 36'(oe));
        i_host.pins(1'b0, 1'b1, 1'b1);
        #1;
        chk("dq_oe sleep", 36'h0, 36'(oe));
        repeat (2) @(negedge mclk);
        chk("sleep flag", 36'h1, 36'(sleeping));
        i_host.pins(1'b0, 1'b0, 1'b1);
        repeat (3) i_host.desel();
        @(negedge mclk);
        chk("sleep flag", 36'h0, 36'(sleeping));
        i_host.rd(1'b0, 18'h00011);
        i_host.desel();
        @(negedge mclk);
        chk("wake read", 36'hABCDEF012, q);
    endtask

    initial begin
        do_reset(1'b1);
        s_lanes();
        s_burst(1'b1, 1'b1);
        s_oe();
        s_sleep();
        do_reset(1'b0);
        s_burst(1'b0, 1'b0);
        end_sim();
    end

    // The scenarios need some nine microseconds; this only cuts a hang short.
    initial begin
        #400000;
        n_errors++;
        end_sim();
    end
endmodule // test_sync_burst_sram_control
